// file: rtl/flash_host_pkg.sv
// Constants, types and timing shared by the flash host controller files
package flash_host_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_KHZ = 25000;
  localparam int ACCESS_NS = 70;
  localparam int WE_PULSE_NS = 50;
  localparam int RECOV_NS = 40;
  localparam int SUSPEND_US = 20;
  localparam int SYNC_CYC = 2;
  localparam int ACCESS_CYC = (ACCESS_NS * CLK_KHZ + 999999) / 1000000;
  localparam int WE_CYC = (WE_PULSE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int RECOV_CYC = (RECOV_NS * CLK_KHZ + 999999) / 1000000;
  localparam int SUSPEND_CYC = (SUSPEND_US * CLK_KHZ + 999) / 1000;
  localparam logic [3:0] RD_CNT = 4'(ACCESS_CYC + SYNC_CYC - 1);
  localparam logic [3:0] WR_CNT = 4'(WE_CYC - 1);
  localparam logic [3:0] RECOV_CNT = 4'(RECOV_CYC - 1);
  localparam logic [9:0] SUSPEND_CNT = 10'(SUSPEND_CYC - 1);

  // ==========================================================================
  // Flash command addresses and data codes
  localparam logic [20:0] UNLOCK1_ADDR = 21'h000555;
  localparam logic [20:0] UNLOCK2_ADDR = 21'h000AAA;
  localparam logic [20:0] LOCK_FLAG_ADDR = 21'h000080;
  localparam logic [20:0] ANY_ADDR = 21'h000000;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] CODE_PROGRAM = 16'h00A0;
  localparam logic [15:0] CODE_SUSPEND = 16'h00B0;
  localparam logic [15:0] CODE_RESUME = 16'h0030;
  localparam logic [15:0] CODE_ID_ENTRY = 16'h0090;
  localparam logic [15:0] CODE_ID_EXIT = 16'h00F0;
  localparam logic [15:0] CODE_PROT = 16'h00C0;
  localparam logic [15:0] CODE_CONFIG = 16'h00D0;
  localparam logic [15:0] LOCK_DATA = 16'h0000;

  // Status bit positions on the data bus
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int SUPPLY_BIT = 3;

  // ==========================================================================
  // Register map (byte offsets) and reset values
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic METHOD_RESET = 1'b0;
  localparam logic [1:0] SETTING_RESET = 2'h0;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_PROGRAM = 4'h1, OP_SUSPEND = 4'h2, OP_RESUME = 4'h3,
    OP_ID_ENTRY = 4'h4, OP_ID_EXIT = 4'h5, OP_ID_EXIT1 = 4'h6, OP_PROT_PROG = 4'h7,
    OP_PROT_LOCK = 4'h8, OP_LOCK_STATUS = 4'h9, OP_PROT_READ = 4'hA, OP_SET_CONFIG = 4'hB,
    OP_RSV_C = 4'hC, OP_RSV_D = 4'hD, OP_RSV_E = 4'hE, OP_RSV_F = 4'hF
  } op_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0, M_ISSUE = 2'h1, M_POLL = 2'h2, M_WAIT = 2'h3
  } main_st_e;

  typedef enum logic [1:0] {
    E_IDLE = 2'h0, E_SETUP = 2'h1, E_STROBE = 2'h2, E_RECOV = 2'h3
  } eng_st_e;

  typedef struct packed {
    logic valid;
    logic we;
    logic [20:0] addr;
    logic [15:0] data;
  } step_s;

endpackage : flash_host_pkg

// file: rtl/flash_cyc_if.sv
// Bus-cycle request channel between the sequencer and the pin engine
interface flash_cyc_if;
  logic req;
  logic we;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;

  modport master (output req, we, addr, wdata, input ack, rdata);
  modport engine (input req, we, addr, wdata, output ack, rdata);
endinterface : flash_cyc_if

// file: rtl/flash_cyc_engine.sv
// Pin engine: one flash read or write cycle per request
module flash_cyc_engine (
  input wire logic clk,
  input wire logic rst,
  flash_cyc_if.engine cyc,
  output logic [20:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_i
);

  // ==========================================================================
  // State
  typedef struct packed {
    flash_host_pkg::eng_st_e st;
    logic [3:0] cnt;
    logic we;
    logic [20:0] addr;
    logic [15:0] dq_o;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic ack;
    logic [15:0] rdata;
    logic [15:0] sync1;
    logic [15:0] sync2;
  } eng_state_s;

  eng_state_s q;
  eng_state_s d;

  // Next state: setup, strobe, recovery
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.sync1 = flash_dq_i;
    d.sync2 = q.sync1;
    unique case (q.st)
      flash_host_pkg::E_IDLE: begin
        if (cyc.req && !q.ack) begin
          d.st = flash_host_pkg::E_SETUP;
          d.we = cyc.we;
          d.addr = cyc.addr;
          d.dq_o = cyc.wdata;
          d.ce_n = 1'b0;
          d.dq_oe = cyc.we;
        end
      end
      flash_host_pkg::E_SETUP: begin
        // Write strobe only falls with output enable high and chip select low
        d.st = flash_host_pkg::E_STROBE;
        d.oe_n = q.we;
        d.we_n = !q.we;
        d.cnt = q.we ? flash_host_pkg::WR_CNT : flash_host_pkg::RD_CNT;
      end
      flash_host_pkg::E_STROBE: begin
        if (q.cnt == 4'h0) begin
          d.st = flash_host_pkg::E_RECOV;
          d.rdata = q.sync2;
          d.we_n = 1'b1;
          d.oe_n = 1'b1;
          d.cnt = flash_host_pkg::RECOV_CNT;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      flash_host_pkg::E_RECOV: begin
        d.ce_n = 1'b1;
        d.dq_oe = 1'b0;
        if (q.cnt == 4'h0) begin
          d.st = flash_host_pkg::E_IDLE;
          d.ack = 1'b1;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
    endcase
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{st: flash_host_pkg::E_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign cyc.ack = q.ack;
  assign cyc.rdata = q.rdata;
  assign flash_addr = q.addr;
  assign flash_ce_n = q.ce_n;
  assign flash_oe_n = q.oe_n;
  assign flash_we_n = q.we_n;
  assign flash_dq_o = q.dq_o;
  assign flash_dq_oe = q.dq_oe;

endmodule : flash_cyc_engine

// file: rtl/flash_host_ctrl.sv
// Wishbone-controlled host sequencer for a parallel NOR flash
// Function
// R1: Wait suspend time after suspend command
// R2: Refuse reads inside suspended program's sector
// R3: Suspend and resume are single write cycles
// R4: Shared suspend and resume codes used
// R5: Identification values same for both entry methods
// R6: Security register has fixed and user halves
// R7: User half written by four-cycle sequence
// R8: Lock sequence drives lock flag zero
// R9: Lock flag read at address 80H
// R10: Security words read after identification entry
// R11: Identification exit after lock or register read
// R12: Completion output low while busy
// R13: No program while output enable low
// R14: Device waits after supply becomes valid
// R15: Device blocks operations after protection voltage
// R16: Status during program under erase suspend
// R17: Timeout error flag on overrun or protection
// R18: Supply fault flag on low protection voltage
// R19: Recheck poll bit after timeout error flag
// R20: Recheck toggle flag after timeout error flag
// R21: Poll at the programmed location
// R22: Status flags during normal program or erase
// R23: Status flags while erase suspended
// R24: Setting 01 needs identification exit after success
// R25: Exit uses F0 data
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
module flash_host_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  output logic [20:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_i,
  input wire logic flash_ready_busy_n
);

  // ==========================================================================
  // Cycle engine
  flash_cyc_if cyc ();

  flash_cyc_engine u_engine (
    .clk(clk),
    .rst(rst),
    .cyc(cyc.engine),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i)
  );

  // ==========================================================================
  // State
  typedef struct packed {
    flash_host_pkg::main_st_e st;
    flash_host_pkg::op_e op;
    logic [3:0] step;
    logic [20:0] addr;
    logic [15:0] wdata;
    logic method;
    logic [1:0] setting;
    logic busy;
    logic done;
    logic fail;
    logic tmo;
    logic vppf;
    logic refused;
    logic susp;
    logic [9:0] susp_sec;
    logic [15:0] rdata;
    logic [15:0] prev;
    logic have_prev;
    logic recheck;
    logic [9:0] wait_cnt;
    logic req;
    logic c_we;
    logic [20:0] c_addr;
    logic [15:0] c_data;
    logic wb_ack;
    logic [31:0] wb_rd;
    logic rb_sync1;
    logic rb_sync2;
  } ctrl_state_s;

  ctrl_state_s q;
  ctrl_state_s d;
  flash_host_pkg::step_s s;
  logic [15:0] r;
  logic wb_req;
  logic wb_wr;
  logic [31:0] wr_val;
  logic poll_ok;
  logic poll_err;
  logic start;

  // ==========================================================================
  // Functions

  // Sector number: small boot sectors at the bottom, large sectors above
  function automatic logic [9:0] sector_of(logic [20:0] a);
    if (a[20:15] == 6'h00) begin
      sector_of = {7'h00, a[14:12]};
    end else begin
      sector_of = {4'h8, a[20:15]};
    end
  endfunction : sector_of

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  // Bus cycle for a step of a command sequence; valid low when it has ended
  function automatic flash_host_pkg::step_s cmd_step(flash_host_pkg::op_e op, logic [3:0] st,
                                                     logic [20:0] a, logic [15:0] dt);
    flash_host_pkg::step_s c;
    logic [15:0] code;
    c = '{valid: 1'b0, we: 1'b1, addr: flash_host_pkg::ANY_ADDR, data: 16'h0000};
    code = flash_host_pkg::CODE_ID_EXIT;
    unique case (op)
      flash_host_pkg::OP_PROGRAM: code = flash_host_pkg::CODE_PROGRAM;
      flash_host_pkg::OP_ID_ENTRY, flash_host_pkg::OP_LOCK_STATUS,
      flash_host_pkg::OP_PROT_READ: code = flash_host_pkg::CODE_ID_ENTRY;
      flash_host_pkg::OP_PROT_PROG, flash_host_pkg::OP_PROT_LOCK: code = flash_host_pkg::CODE_PROT;
      flash_host_pkg::OP_SET_CONFIG: code = flash_host_pkg::CODE_CONFIG;
      default: code = flash_host_pkg::CODE_ID_EXIT; // [R25]
    endcase
    unique case (op)
      flash_host_pkg::OP_READ: begin
        c = '{valid: (st == 4'h0), we: 1'b0, addr: a, data: 16'h0000};
      end
      flash_host_pkg::OP_SUSPEND: begin
        c.valid = (st == 4'h0); // [R3] [R4]
        c.data = flash_host_pkg::CODE_SUSPEND;
      end
      flash_host_pkg::OP_RESUME: begin
        c.valid = (st == 4'h0); // [R3] [R4]
        c.data = flash_host_pkg::CODE_RESUME;
      end
      flash_host_pkg::OP_ID_EXIT1: begin
        c.valid = (st == 4'h0);
        c.data = flash_host_pkg::CODE_ID_EXIT; // [R25]
      end
      flash_host_pkg::OP_RSV_C, flash_host_pkg::OP_RSV_D, flash_host_pkg::OP_RSV_E,
      flash_host_pkg::OP_RSV_F: begin
        c.valid = 1'b0;
      end
      default: begin
        unique case (st)
          4'h0: c = '{valid: 1'b1, we: 1'b1, addr: flash_host_pkg::UNLOCK1_ADDR,
                      data: flash_host_pkg::UNLOCK1_DATA};
          4'h1: c = '{valid: 1'b1, we: 1'b1, addr: flash_host_pkg::UNLOCK2_ADDR,
                      data: flash_host_pkg::UNLOCK2_DATA};
          4'h2: c = '{valid: 1'b1, we: 1'b1, addr: flash_host_pkg::UNLOCK1_ADDR, data: code};
          4'h3: begin
            unique case (op)
              flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_PROT_PROG: begin
                c = '{valid: 1'b1, we: 1'b1, addr: a, data: dt}; // [R7]
              end
              flash_host_pkg::OP_PROT_LOCK: begin
                c = '{valid: 1'b1, we: 1'b1, addr: flash_host_pkg::LOCK_FLAG_ADDR,
                      data: flash_host_pkg::LOCK_DATA}; // [R8]
              end
              flash_host_pkg::OP_LOCK_STATUS: begin
                c = '{valid: 1'b1, we: 1'b0, addr: flash_host_pkg::LOCK_FLAG_ADDR,
                      data: 16'h0000}; // [R9]
              end
              flash_host_pkg::OP_PROT_READ: begin
                c = '{valid: 1'b1, we: 1'b0, addr: a, data: 16'h0000}; // [R10] [R6]
              end
              flash_host_pkg::OP_SET_CONFIG: begin
                c = '{valid: 1'b1, we: 1'b1, addr: flash_host_pkg::ANY_ADDR,
                      data: {14'h0000, dt[1:0]}};
              end
              default: c.valid = 1'b0;
            endcase
          end
          default: c.valid = 1'b0;
        endcase
      end
    endcase
    cmd_step = c;
  endfunction : cmd_step

  // ==========================================================================
  // Decode helpers
  assign wb_req = wb_cyc && wb_stb && !q.wb_ack;
  assign wb_wr = wb_cyc && wb_stb && wb_we && q.wb_ack;
  assign start = wb_wr && (wb_adr == flash_host_pkg::REG_CTRL) && !q.busy;
  assign s = cmd_step(q.op, q.step, q.addr, q.wdata);
  assign r = cyc.rdata;

  // Poll decision: data polling or toggle comparison
  always_comb begin
    poll_err = r[flash_host_pkg::TIMEOUT_BIT] || r[flash_host_pkg::SUPPLY_BIT]; // [R17] [R18]
    if (q.method) begin
      poll_ok = q.have_prev && (r[flash_host_pkg::TOGGLE_BIT] == q.prev[flash_host_pkg::TOGGLE_BIT]);
    end else if (q.setting == 2'h0) begin
      poll_ok = (r[flash_host_pkg::POLL_BIT] ==
                 ((q.op == flash_host_pkg::OP_PROT_LOCK) ? flash_host_pkg::LOCK_DATA[7] :
                  q.wdata[flash_host_pkg::POLL_BIT]));
    end else begin
      poll_ok = r[flash_host_pkg::POLL_BIT];
    end
  end

  // Wishbone read data mux
  always_comb begin
    wr_val = 32'h00000000;
    unique case (wb_adr)
      flash_host_pkg::REG_CTRL: wr_val = {28'h0000000, q.op};
      flash_host_pkg::REG_ADDR: wr_val = {11'h000, q.addr};
      flash_host_pkg::REG_WDATA: wr_val = {16'h0000, q.wdata};
      flash_host_pkg::REG_CFG: wr_val = {31'h00000000, q.method};
      flash_host_pkg::REG_STATUS: wr_val = {22'h000000, q.setting, q.rb_sync2, q.susp,
                                           q.refused, q.vppf, q.tmo, q.fail, q.done, q.busy};
      flash_host_pkg::REG_RDATA: wr_val = {16'h0000, q.rdata};
      default: wr_val = 32'h00000000;
    endcase
  end

  // Next state: register writes and command sequencing
  always_comb begin
    d = q;
    d.wb_ack = wb_req;
    d.rb_sync1 = flash_ready_busy_n; // [R12]
    d.rb_sync2 = q.rb_sync1;
    if (wb_req) begin
      d.wb_rd = wr_val;
    end
    if (wb_wr && !q.busy) begin
      unique case (wb_adr)
        flash_host_pkg::REG_ADDR: d.addr = 21'(merge({11'h000, q.addr}, wb_dat_w, wb_sel));
        flash_host_pkg::REG_WDATA: d.wdata = 16'(merge({16'h0000, q.wdata}, wb_dat_w, wb_sel));
        flash_host_pkg::REG_CFG: begin
          if (wb_sel[0]) begin
            d.method = wb_dat_w[0];
          end
        end
        default: begin
        end
      endcase
    end
    unique case (q.st)
      flash_host_pkg::M_IDLE: begin
        if (start && wb_sel[0]) begin
          d.op = flash_host_pkg::op_e'(wb_dat_w[3:0]);
          d.done = 1'b0;
          d.fail = 1'b0;
          d.tmo = 1'b0;
          d.vppf = 1'b0;
          d.refused = 1'b0;
          d.step = 4'h0;
          if ((wb_dat_w[3:0] == flash_host_pkg::OP_READ) && q.susp &&
              (sector_of(q.addr) == q.susp_sec)) begin
            d.refused = 1'b1; // [R2]
            d.done = 1'b1;
          end else begin
            d.busy = 1'b1;
            d.st = flash_host_pkg::M_ISSUE;
          end
        end
      end
      flash_host_pkg::M_ISSUE: begin
        if (q.req) begin
          if (cyc.ack) begin
            d.req = 1'b0;
            d.step = q.step + 4'h1;
            if (!q.c_we) begin
              d.rdata = r;
            end
          end
        end else if (s.valid) begin
          d.req = 1'b1;
          d.c_we = s.we;
          d.c_addr = s.addr;
          d.c_data = s.data;
        end else begin
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st = flash_host_pkg::M_IDLE;
          unique case (q.op)
            flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_PROT_PROG,
            flash_host_pkg::OP_PROT_LOCK: begin
              d.busy = 1'b1;
              d.done = 1'b0;
              d.st = flash_host_pkg::M_POLL;
              d.have_prev = 1'b0;
              d.recheck = 1'b0;
            end
            flash_host_pkg::OP_SUSPEND: begin
              d.busy = 1'b1;
              d.done = 1'b0;
              d.st = flash_host_pkg::M_WAIT;
              d.wait_cnt = flash_host_pkg::SUSPEND_CNT; // [R1]
              d.susp = 1'b1;
            end
            flash_host_pkg::OP_RESUME: d.susp = 1'b0;
            flash_host_pkg::OP_SET_CONFIG: d.setting = q.wdata[1:0];
            flash_host_pkg::OP_LOCK_STATUS, flash_host_pkg::OP_PROT_READ: begin
              d.busy = 1'b1;
              d.done = 1'b0;
              d.op = flash_host_pkg::OP_ID_EXIT; // [R11]
              d.step = 4'h0;
              d.st = flash_host_pkg::M_ISSUE;
            end
            default: begin
            end
          endcase
        end
      end
      flash_host_pkg::M_POLL: begin
        if (!q.req) begin
          d.req = 1'b1;
          d.c_we = 1'b0;
          d.c_addr = (q.op == flash_host_pkg::OP_PROT_LOCK) ? flash_host_pkg::LOCK_FLAG_ADDR :
                     q.addr; // [R21]
        end else if (cyc.ack) begin
          d.req = 1'b0;
          d.rdata = r;
          d.prev = r;
          d.have_prev = 1'b1;
          if (poll_ok || q.recheck) begin
            // Success, or a recheck that still shows busy is a failure
            d.fail = !poll_ok;
            d.susp_sec = sector_of(q.addr);
            d.step = 4'h0;
            if (!poll_ok || (q.setting != 2'h0)) begin
              d.op = flash_host_pkg::OP_ID_EXIT; // [R24]
              d.st = flash_host_pkg::M_ISSUE;
            end else begin
              d.busy = 1'b0;
              d.done = 1'b1;
              d.st = flash_host_pkg::M_IDLE;
            end
          end else if (poll_err && (!q.method || q.have_prev)) begin
            d.recheck = 1'b1; // [R19] [R20]
            d.tmo = r[flash_host_pkg::TIMEOUT_BIT];
            d.vppf = r[flash_host_pkg::SUPPLY_BIT];
          end
        end
      end
      flash_host_pkg::M_WAIT: begin
        if (q.wait_cnt == 10'h000) begin
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st = flash_host_pkg::M_IDLE;
        end else begin
          d.wait_cnt = q.wait_cnt - 10'h001; // [R1]
        end
      end
    endcase
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{st: flash_host_pkg::M_IDLE, op: flash_host_pkg::OP_READ,
             method: flash_host_pkg::METHOD_RESET, setting: flash_host_pkg::SETTING_RESET,
             rb_sync1: 1'b1, rb_sync2: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign cyc.req = q.req;
  assign cyc.we = q.c_we;
  assign cyc.addr = q.c_addr;
  assign cyc.wdata = q.c_data;
  assign wb_ack = q.wb_ack;
  assign wb_dat_r = q.wb_rd;

endmodule : flash_host_ctrl

// file: test/flash_host_props.sv
// Checker of pin strobes and bus answers of the flash host controller
module flash_host_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_ack,
  input wire logic [20:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [15:0] flash_dq_o,
  input wire logic flash_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Strobe shapes
  sequence we_pulse_s;
    !flash_we_n [*2] ##1 flash_we_n;
  endsequence
  sequence rd_pulse_s;
    !flash_oe_n [*4] ##1 flash_oe_n;
  endsequence
  we_len_a: assert property ($fell(flash_we_n) |-> we_pulse_s)
    else $error("write strobe length wrong");
  oe_len_a: assert property ($fell(flash_oe_n) |-> rd_pulse_s)
    else $error("read strobe length wrong");
  we_gate_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("write strobe outside a driven select");
  rd_gate_a: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe)
    else $error("read strobe with bus driven");
  wr_hold_a: assert property (!flash_we_n |=> $stable(flash_addr) && $stable(flash_dq_o))
    else $error("address or data moved in write");
  ce_setup_a: assert property ($fell(flash_ce_n) |-> flash_we_n && flash_oe_n)
    else $error("strobe without setup cycle");
  ack_resp_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("bus answer late");
  ack_once_a: assert property (wb_ack |=> !wb_ack)
    else $error("bus answer too long");
endmodule : flash_host_props

bind flash_host_ctrl flash_host_props u_props (.clk, .rst, .wb_cyc, .wb_stb, .wb_ack,
  .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_o, .flash_dq_oe);

// file: test/flash_dev_model.sv
// Behavioural model of the flash device
module flash_dev_model (
  input wire logic [20:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] wd,
  output logic [15:0] rd,
  output logic rdy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sec [16];
  logic [15:0] o = 16'h0000;
  logic [15:0] pd = 16'h0000;
  logic [20:0] pa = 21'h1FFFFF;
  logic [7:0] pend = 8'h00;
  logic [7:0] p;
  logic id = 1'h0;
  logic lk = 1'h0;
  logic err = 1'h0;
  logic tg = 1'h0;
  int n = 0;
  int busy = 0;
  int nsus = 0;
  int nres = 0;
  // Factory words fixed, user words writable
  initial for (int i = 0; i < 16; i++) sec[i] = 16'hC000 + 16'(i);
  // Released bus shows inverted last word
  assign rd = (!oe_n && !ce_n) ? o : ~o;
  assign rdy_n = (busy == 0);
  // Command cycles taken at write strobe rise
  always @(posedge we_n) begin
    if (!ce_n && oe_n) begin
      p = pend;
      pend = 8'h00;
      if (p == 8'hA0 || p == 8'hC0) begin
        pa = addr;
        pd = wd;
        if (p == 8'hC0 && addr == 21'h80 && !wd[1]) lk = 1'h1;
        else if (p == 8'hC0 && lk) err = 1'h1;
        else if (p == 8'hC0 && addr[3:0] > 4'h4) sec[addr[3:0]] = wd;
        busy = err ? 0 : 3;
      end else if (wd[7:0] == 8'hB0) nsus++;
      else if (wd[7:0] == 8'h30) nres++;
      else if (n == 2 && wd[7:0] == 8'h90) id = 1'h1;
      else if (n == 2 && wd[7:0] != 8'hF0) pend = wd[7:0];
      else if (n != 1 && wd[7:0] != 8'hAA) begin
        id = 1'h0;
        err = 1'h0;
      end
      n = (addr == 21'h555 && wd[7:0] == 8'hAA) ? 1 : (n == 1 && wd[7:0] == 8'h55) ? 2 : 0;
    end
  end
  // Status or data chosen at read strobe
  always @(negedge oe_n) begin
    if (busy > 0 || err) begin
      o = 16'h0004;
      o[7] = ~pd[7];
      o[6] = tg;
      o[5] = err;
      tg = ~tg;
      if (busy > 0) busy--;
    end else if (id) o = (addr == 21'h80) ? {14'h0, ~lk, 1'h0} : sec[addr[3:0]];
    else o = (addr == pa) ? pd : addr[15:0];
  end
endmodule : flash_dev_model

// file: test/flash_host_ctrl_tb_top.sv
// Self-checking testbench of the flash host controller
module flash_host_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic wb_cyc = 1'h0;
  logic wb_stb = 1'h0;
  logic wb_we = 1'h0;
  logic wb_ack, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, ready_n;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r, q;
  logic [20:0] flash_addr;
  logic [15:0] flash_dq_o, flash_dq_i;
  int num_errors = 0;
  int n_checks = 0;
  int cyc_n;
  flash_host_ctrl u_dut (.clk, .rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel(4'hF),
    .wb_dat_w, .wb_dat_r, .wb_ack, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ready_busy_n(ready_n));
  flash_dev_model u_dev (.addr(flash_addr), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n), .wd(flash_dq_o), .rd(flash_dq_i), .rdy_n(ready_n));
  // ==========================================================================
  // Bus tasks
  initial forever #20 clk = ~clk;
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    do @(posedge clk); while (wb_ack !== 1'h1);
    q = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask : wb
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  // Start an operation and wait while busy
  task automatic op(input logic [3:0] o);
    time t0;
    t0 = $time;
    wb(1'h1, flash_host_pkg::REG_CTRL, {28'h0, o});
    do wb(1'h0, flash_host_pkg::REG_STATUS, 32'h0); while (q[0] === 1'h1);
    cyc_n = int'(($time - t0) / 40);
  endtask : op
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    wb(1'h0, flash_host_pkg::REG_STATUS, 32'h0);
    chk(q & m, e);
  endtask : st
  task automatic rdat(input logic [31:0] m, input logic [31:0] e);
    wb(1'h0, flash_host_pkg::REG_RDATA, 32'h0);
    chk(q & m, e);
  endtask : rdat
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    st(32'h3FF, 32'h080);
    wb(1'h0, 8'h40, 32'h0);
    chk(q, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_prog;
    for (int m = 0; m < 2; m++) begin
      wb(1'h1, flash_host_pkg::REG_CFG, 32'(m));
      wb(1'h1, flash_host_pkg::REG_ADDR, 32'h12345);
      wb(1'h1, flash_host_pkg::REG_WDATA, 32'h5A3C);
      op(4'h1);
      st(32'h7, 32'h2);
      op(4'h0);
      rdat(32'hFFFF, 32'h5A3C);
    end
    $display("t_prog done");
  endtask : t_prog
  task automatic t_susp;
    op(4'h2);
    chk(32'(cyc_n >= 500), 32'h1);
    chk(u_dev.nsus, 32'h1);
    st(32'h40, 32'h40);
    op(4'h0);
    st(32'h20, 32'h20);
    op(4'h3);
    chk(u_dev.nres, 32'h1);
    op(4'h0);
    rdat(32'hFFFF, 32'h5A3C);
    $display("t_susp done");
  endtask : t_susp
  task automatic t_sec;
    wb(1'h1, flash_host_pkg::REG_ADDR, 32'h85);
    wb(1'h1, flash_host_pkg::REG_WDATA, 32'hBEEF);
    op(4'h7);
    op(4'hA);
    rdat(32'hFFFF, 32'hBEEF);
    chk(u_dev.id, 32'h0);
    wb(1'h1, flash_host_pkg::REG_ADDR, 32'h81);
    op(4'hA);
    rdat(32'hFFFF, 32'hC001);
    $display("t_sec done");
  endtask : t_sec
  task automatic t_lock;
    op(4'h9);
    rdat(32'h2, 32'h2);
    op(4'h8);
    op(4'h9);
    rdat(32'h2, 32'h0);
    chk(u_dev.id, 32'h0);
    wb(1'h1, flash_host_pkg::REG_ADDR, 32'h86);
    op(4'h7);
    st(32'hC, 32'hC);
    chk(u_dev.err, 32'h0);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_modes;
    op(4'h4);
    chk(u_dev.id, 32'h1);
    op(4'h6);
    chk(u_dev.id, 32'h0);
    op(4'h4);
    op(4'h5);
    chk(u_dev.id, 32'h0);
    wb(1'h1, flash_host_pkg::REG_WDATA, 32'h1);
    for (int o = 11; o < 16; o++) begin
      op(4'(o));
      st(32'h306, 32'h102);
    end
    $display("t_modes done");
  endtask : t_modes
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_prog();
    t_susp();
    t_sec();
    t_lock();
    t_modes();
    test_done();
  end
  initial begin
    #2000000;
    num_errors++;
    test_done();
  end
endmodule : flash_host_ctrl_tb_top
